//--- hw/sbic_host_port.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Read and write strobes low together reset the whole chip.
// - The vector is driven only while acknowledge and read are both low.
// - Strobes are synchronised to the local clock before any use.
// - No new interrupt request is raised during an acknowledge cycle.
// - Events set pending flags and an acknowledge leaves them unchanged.
// - Pending flags clear by command or when their cause is serviced.
// - An acknowledge sets in-service only with a pending flag and CHAIN_ENABLE_IN high.
// - In-service flags clear only by software command or by strobe reset.
// - Outside acknowledge, enable-out is enable-in with no flag in service.
// - During acknowledge, enable-out is low on low CHAIN_ENABLE_IN, pending or service.
// - A lower-chain-disable command forces enable-out low.
// - The acknowledging read drives the vector and sets in-service at once.
module sbic_host_port
	import sbic_pkg::*;
(
	input wire logic I_MCLK,
	input wire logic I_RST_B,
	input wire logic [1:0] I_REG_SEL,
	input wire logic I_CE_N,
	input wire logic I_RD_N,
	input wire logic I_WR_N,
	input wire logic I_IRQ_ACK_N,
	input wire logic [7:0] I_DATA_BUS,
	output logic [7:0] O_DATA_BUS,
	output logic O_DATA_BUS_OE_N,
	input wire logic I_IRQ_N,
	output logic O_IRQ_N,
	output logic O_IRQ_OE_N,
	input wire logic I_CHAIN_ENABLE_IN,
	output logic O_CHAIN_ENABLE_OUT,
	input wire logic I_EV_TX_EMPTY,
	input wire logic I_EV_RX_AVAIL,
	input wire logic I_EV_ERROR,
	input wire logic I_EV_STAT_CHG,
	input wire logic [7:0] I_RX_DATA,
	output logic O_RX_READ,
	output logic [7:0] O_TX_DATA,
	output logic O_TX_LOAD,
	output logic O_CHIP_RESET
);

	function automatic logic [1:0] hi_pri(input logic [N_SRC-1:0] f);
		logic [1:0] idx;
		idx = 2'h0;
		for (int i = N_SRC - 1; i >= 0; i--)
			if (f[i])
				idx = 2'(i);
		return idx;
	endfunction : hi_pri

	function automatic logic [N_SRC-1:0] one_hot(input logic [1:0] idx);
		return 4'h1 << idx;
	endfunction : one_hot

	logic [SYNC_W-1:0] sync_q;
	logic ce_s, rd_s, wr_s, ack_s, cei_s, irq_pin_s;
	logic [1:0] rs_s;
	logic [7:0] data_s;

	sbic_sync #(
		.W(SYNC_W),
		.RST(SYNC_RST)
	) u_sync (
		.i_clk(I_MCLK),
		.i_rst_b(I_RST_B),
		.i_d({I_CE_N, I_RD_N, I_WR_N, I_IRQ_ACK_N, I_REG_SEL,
			I_CHAIN_ENABLE_IN, I_IRQ_N, I_DATA_BUS}),
		.o_q(sync_q)
	);

	assign {ce_s, rd_s, wr_s, ack_s, rs_s, cei_s, irq_pin_s, data_s} = sync_q;

	sbic_acc_e state_ff, nxt_state;
	logic [N_SRC-1:0] pend_ff, nxt_pend, ius_ff, nxt_ius, ev_set, pend_clr;
	logic [7:0] rd_data_ff, vec_base_ff, tx_data_ff;
	logic drive_ff, dlc_ff, int_ff, ceo_ff, rx_read_ff, tx_load_ff, srst_ff;
	logic srst, in_ack, ack_hit, rd_start, wr_start, ack_start, soft_rst;
	logic int_cond;
	logic [7:0] vector;

	assign srst = !rd_s && !wr_s;
	assign in_ack = !ack_s;
	assign ack_hit = cei_s && (|pend_ff);
	assign vector = {vec_base_ff[7:2], hi_pri(pend_ff)};

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ACC_IDLE:
				if (!rd_s && !ack_s)
					nxt_state = ACC_ACK;
				else if (!rd_s && !ce_s)
					nxt_state = ACC_READ;
				else if (!wr_s && !ce_s)
					nxt_state = ACC_WRITE;
			ACC_READ:
				if (rd_s)
					nxt_state = ACC_IDLE;
			// Losing either strobe ends the cycle, so the vector never
			// outlives the pair that gates it.
			ACC_ACK:
				if (rd_s || ack_s)
					nxt_state = ACC_IDLE;
			ACC_WRITE:
				if (wr_s)
					nxt_state = ACC_IDLE;
			default:
				nxt_state = ACC_IDLE;
		endcase
		if (srst)
			nxt_state = ACC_IDLE;
	end

	assign rd_start = state_ff == ACC_IDLE && nxt_state == ACC_READ;
	assign wr_start = state_ff == ACC_IDLE && nxt_state == ACC_WRITE;
	assign ack_start = state_ff == ACC_IDLE && nxt_state == ACC_ACK;
	assign soft_rst = wr_start && rs_s == REG_CTRL && data_s == CMD_SOFT_RESET;

	always_ff @(posedge I_MCLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
			state_ff <= ACC_IDLE;
		else
			state_ff <= nxt_state;
	end

	assign ev_set = {I_EV_STAT_CHG, I_EV_TX_EMPTY, I_EV_RX_AVAIL, I_EV_ERROR};

	always_comb
	begin
		pend_clr = '0;
		if (rd_start && rs_s == REG_DATA)
			pend_clr[SRC_RX] = 1'b1;
		if (wr_start && rs_s == REG_DATA)
			pend_clr[SRC_TX] = 1'b1;
		if (wr_start && rs_s == REG_CTRL)
		begin
			if (data_s == CMD_RST_TX_PEND)
				pend_clr[SRC_TX] = 1'b1;
			if (data_s == CMD_RST_ERR_PEND)
				pend_clr[SRC_ERR] = 1'b1;
			if (data_s == CMD_RST_STAT_PEND)
				pend_clr[SRC_STAT] = 1'b1;
		end
		// An event in the clearing cycle survives; acknowledge clears none.
		nxt_pend = (pend_ff & ~pend_clr) | ev_set;
		if (srst || soft_rst)
			nxt_pend = FLAGS_RST;
	end

	always_comb
	begin
		nxt_ius = ius_ff;
		if (ack_start && ack_hit)
			nxt_ius = ius_ff | one_hot(hi_pri(pend_ff));
		if (wr_start && rs_s == REG_CTRL && data_s == CMD_RST_IN_SERVICE)
			nxt_ius = ius_ff & ~one_hot(hi_pri(ius_ff));
		if (srst || soft_rst)
			nxt_ius = FLAGS_RST;
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			pend_ff <= FLAGS_RST;
			ius_ff <= FLAGS_RST;
		end
		else
		begin
			pend_ff <= nxt_pend;
			ius_ff <= nxt_ius;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
			dlc_ff <= 1'b0;
		else if (srst || soft_rst)
			dlc_ff <= 1'b0;
		else if (wr_start && rs_s == REG_CTRL)
		begin
			if (data_s == CMD_LOWER_CHAIN_DISABLE)
				dlc_ff <= 1'b1;
			else if (data_s == CMD_LOWER_CHAIN_ENABLE)
				dlc_ff <= 1'b0;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
			vec_base_ff <= VECTOR_BASE_RST;
		else if (srst || soft_rst)
			vec_base_ff <= VECTOR_BASE_RST;
		else if (wr_start && rs_s == REG_VECTOR)
			vec_base_ff <= data_s;
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			tx_data_ff <= DATA_RST;
			tx_load_ff <= 1'b0;
			rx_read_ff <= 1'b0;
			srst_ff <= 1'b0;
		end
		else
		begin
			tx_load_ff <= wr_start && rs_s == REG_DATA;
			rx_read_ff <= rd_start && rs_s == REG_DATA;
			srst_ff <= srst || soft_rst;
			if (wr_start && rs_s == REG_DATA)
				tx_data_ff <= data_s;
		end
	end

	// Read data is captured once at the start so it holds for the strobe.
	always_ff @(posedge I_MCLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
			rd_data_ff <= DATA_RST;
		else if (ack_start && ack_hit)
			rd_data_ff <= vector;
		else if (rd_start)
		begin
			case (rs_s)
				REG_CTRL: rd_data_ff <= {ius_ff, pend_ff};
				REG_DATA: rd_data_ff <= I_RX_DATA;
				REG_VECTOR: rd_data_ff <= vec_base_ff;
				default: rd_data_ff <= {4'h0, dlc_ff, cei_s, ceo_ff, !irq_pin_s};
			endcase
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
			drive_ff <= 1'b0;
		else if (nxt_state == ACC_IDLE)
			drive_ff <= 1'b0;
		else if (rd_start || (ack_start && ack_hit))
			drive_ff <= 1'b1;
	end

	assign int_cond = (|pend_ff) && !(|ius_ff) && cei_s;

	always_ff @(posedge I_MCLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
			int_ff <= 1'b0;
		else if (in_ack)
			int_ff <= int_ff && int_cond;
		else
			int_ff <= int_cond;
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
			ceo_ff <= 1'b0;
		else if (dlc_ff)
			ceo_ff <= 1'b0;
		else if (in_ack)
			ceo_ff <= cei_s && !(|pend_ff) && !(|ius_ff);
		else
			ceo_ff <= cei_s && !(|ius_ff);
	end

	assign O_DATA_BUS = rd_data_ff;
	assign O_DATA_BUS_OE_N = !drive_ff;
	assign O_IRQ_N = 1'b0;
	assign O_IRQ_OE_N = !int_ff;
	assign O_CHAIN_ENABLE_OUT = ceo_ff;
	assign O_RX_READ = rx_read_ff;
	assign O_TX_DATA = tx_data_ff;
	assign O_TX_LOAD = tx_load_ff;
	assign O_CHIP_RESET = srst_ff;

	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (!I_RST_B);

	sequence s_ack_taken;
		ack_start && ack_hit;
	endsequence
	sequence s_vector_out;
		!O_DATA_BUS_OE_N && O_DATA_BUS[1:0] == $past(hi_pri(pend_ff));
	endsequence

	a_chip_reset_all: assert property (
		srst |=> pend_ff == FLAGS_RST && ius_ff == FLAGS_RST && !dlc_ff
	) else $error("strobe reset left flags set");
	// The drive register lags the strobes by one edge, hence the past view.
	a_vector_gated: assert property (
		(!O_DATA_BUS_OE_N && state_ff == ACC_ACK) |->
			$past(!ack_s && !rd_s)
	) else $error("vector driven outside acknowledge read");
	a_strobe_synced: assert property (
		rd_start |-> !$past(I_RD_N, 2)
	) else $error("read started without synchronised strobe");
	a_no_new_irq: assert property (
		(in_ack && !int_ff) |=> !int_ff
	) else $error("interrupt raised during acknowledge");
	a_ack_keeps_pend: assert property (
		ack_start |=> (pend_ff & $past(pend_ff)) == $past(pend_ff)
	) else $error("acknowledge cleared a pending flag");
	a_rx_read_clears: assert property (
		(rd_start && rs_s == REG_DATA && !I_EV_RX_AVAIL) |=>
			!pend_ff[SRC_RX] && O_RX_READ
	) else $error("receive read did not clear pending");
	a_no_hit_no_flag: assert property (
		(ack_start && !ack_hit) |=> ius_ff == $past(ius_ff) ##1
			O_DATA_BUS_OE_N
	) else $error("service set without pending and enable");
	a_ius_sw_only: assert property (
		|($past(ius_ff) & ~ius_ff) |-> $past(wr_start || srst)
	) else $error("in-service cleared without command");
	a_idle_chain: assert property (
		(!in_ack && cei_s && ius_ff == FLAGS_RST && !dlc_ff) |=>
			O_CHAIN_ENABLE_OUT
	) else $error("enable-out low in idle with chain free");
	a_ack_chain_low: assert property (
		(in_ack && (!cei_s || (|pend_ff) || (|ius_ff))) |=>
			!O_CHAIN_ENABLE_OUT
	) else $error("enable-out high in acknowledge");
	a_dlc_forces_low: assert property (
		dlc_ff |=> !O_CHAIN_ENABLE_OUT
	) else $error("lower chain disable ignored");
	a_ack_vector: assert property (
		s_ack_taken |=> s_vector_out and (|(ius_ff & ~$past(ius_ff)))
	) else $error("acknowledge did not drive vector and set service");
	a_irq_release: assert property (
		(|ius_ff || !cei_s) |=> O_IRQ_OE_N
	) else $error("interrupt asserted while blocked");

endmodule : sbic_host_port

//--- hw/sbic_pkg.sv
package sbic_pkg;

	// Register select codes seen on the two register-select lines.
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_DATA = 2'h1;
	localparam logic [1:0] REG_VECTOR = 2'h2;
	localparam logic [1:0] REG_CHAIN = 2'h3;

	// Command codes written to the control register.
	localparam logic [7:0] CMD_RST_TX_PEND = 8'h28;
	localparam logic [7:0] CMD_RST_ERR_PEND = 8'h30;
	localparam logic [7:0] CMD_RST_STAT_PEND = 8'h10;
	localparam logic [7:0] CMD_RST_IN_SERVICE = 8'h38;
	localparam logic [7:0] CMD_LOWER_CHAIN_DISABLE = 8'h01;
	localparam logic [7:0] CMD_LOWER_CHAIN_ENABLE = 8'h02;
	localparam logic [7:0] CMD_SOFT_RESET = 8'hC0;

	// Interrupt sources, index 0 has the highest priority.
	localparam int N_SRC = 4;
	localparam logic [1:0] SRC_ERR = 2'h0;
	localparam logic [1:0] SRC_RX = 2'h1;
	localparam logic [1:0] SRC_TX = 2'h2;
	localparam logic [1:0] SRC_STAT = 2'h3;

	// Reset values.
	localparam logic [7:0] VECTOR_BASE_RST = 8'h00;
	localparam logic [N_SRC-1:0] FLAGS_RST = 4'h0;
	localparam logic [7:0] DATA_RST = 8'h00;

	// Bundle of pin inputs taken through the synchroniser.
	localparam int SYNC_W = 16;
	localparam logic [SYNC_W-1:0] SYNC_RST = 16'hFFFF;

	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_READ,
		ACC_WRITE,
		ACC_ACK
	} sbic_acc_e;

endpackage : sbic_pkg

//--- hw/sbic_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser; the first stage is read by the second alone.
module sbic_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);

	logic [W-1:0] meta_ff;

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			meta_ff <= RST;
			o_q <= RST;
		end
		else
		begin
			meta_ff <= i_d;
			o_q <= meta_ff;
		end
	end

endmodule : sbic_sync

//--- testbench/sbic_host_model.sv
`timescale 1ns/1ns
// Host processor side: drives strobes and resolves the shared data bus.
module sbic_host_model (
	input wire logic i_clk,
	input wire logic [7:0] i_dev_data,
	input wire logic i_dev_oe_n,
	output logic [1:0] o_reg_sel,
	output logic o_ce_n,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic o_ack_n,
	output logic [7:0] o_bus
);
	logic io_request_n = 1'b1;
	logic drive = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] last = 8'h00;
	initial
	begin
		o_reg_sel = 2'h0;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_ack_n = 1'b1;
	end
	// The decode always hits, so select follows the I/O request alone.
	assign o_ce_n = io_request_n;
	// An undriven bus shows the inverse of its last value, not a copy.
	assign o_bus = !i_dev_oe_n ? i_dev_data : (drive ? wdata : ~last);
	always @(posedge i_clk)
		if (!i_dev_oe_n || drive)
			last <= o_bus;

	task access(input logic rd, input logic [1:0] sel, input logic [7:0] wd,
		output logic [7:0] rdat);
		@(negedge i_clk);
		o_reg_sel = sel;
		io_request_n = 1'b0;
		wdata = wd;
		drive = !rd;
		@(negedge i_clk);
		if (rd)
			o_rd_n = 1'b0;
		else
			o_wr_n = 1'b0;
		repeat (6) @(posedge i_clk);
		rdat = o_bus;
		@(negedge i_clk);
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		@(negedge i_clk);
		io_request_n = 1'b1;
		drive = 1'b0;
		repeat (4) @(negedge i_clk);
	endtask : access

	// Acknowledge leads the read so that the chain can settle first.
	task ack(output logic [7:0] rdat);
		@(negedge i_clk);
		o_ack_n = 1'b0;
		repeat (3) @(negedge i_clk);
		o_rd_n = 1'b0;
		repeat (6) @(posedge i_clk);
		rdat = o_bus;
		@(negedge i_clk);
		o_rd_n = 1'b1;
		@(negedge i_clk);
		o_ack_n = 1'b1;
		repeat (4) @(negedge i_clk);
	endtask : ack

	task set_ack(input logic v);
		@(negedge i_clk);
		o_ack_n = v;
	endtask : set_ack

	task strobe_reset();
		@(negedge i_clk);
		o_rd_n = 1'b0;
		o_wr_n = 1'b0;
		repeat (8) @(negedge i_clk);
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		repeat (4) @(negedge i_clk);
	endtask : strobe_reset
endmodule : sbic_host_model

//--- testbench/test_sbic_host_port.sv
`timescale 1ns/1ns
module test_sbic_host_port;
	import sbic_pkg::*;
	typedef struct {
		logic [3:0] ev;
		logic [7:0] vec;
		logic rd;
		logic [1:0] sel;
		logic [7:0] wd;
	} sbic_row_s;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [1:0] reg_sel;
	logic ce_n, rd_n, wr_n, ack_n, dev_oe_n, irq_n, irq_oe_n, irq_wire;
	logic chain_enable_out, rx_read, tx_load, chip_reset;
	logic chain_enable_in = 1'b1;
	logic [3:0] ev = 4'h0;
	logic [7:0] bus, dev_data, tx_data, d;
	logic [7:0] rx_data = 8'h3C;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	int tx_loads = 0;
	int rx_reads = 0;
	int resets = 0;
	sbic_row_s rows [4] = '{
		'{4'h1, 8'hA4, 1'b0, REG_CTRL, CMD_RST_ERR_PEND},
		'{4'h2, 8'hA5, 1'b1, REG_DATA, 8'h00},
		'{4'h4, 8'hA6, 1'b0, REG_DATA, 8'h5A},
		'{4'h8, 8'hA7, 1'b0, REG_CTRL, CMD_RST_STAT_PEND}};

	always #2 clk = ~clk;
	// The interrupt wire has a pull-up; the device can only pull it low.
	assign irq_wire = irq_oe_n ? 1'b1 : irq_n;

	sbic_host_model sbic_host_model_inst (.i_clk(clk), .i_dev_data(dev_data),
		.i_dev_oe_n(dev_oe_n), .o_reg_sel(reg_sel), .o_ce_n(ce_n),
		.o_rd_n(rd_n), .o_wr_n(wr_n), .o_ack_n(ack_n), .o_bus(bus));

	sbic_host_port sbic_host_port_inst (.I_MCLK(clk), .I_RST_B(rst_b),
		.I_REG_SEL(reg_sel), .I_CE_N(ce_n), .I_RD_N(rd_n), .I_WR_N(wr_n),
		.I_IRQ_ACK_N(ack_n), .I_DATA_BUS(bus), .O_DATA_BUS(dev_data),
		.O_DATA_BUS_OE_N(dev_oe_n), .I_IRQ_N(irq_wire), .O_IRQ_N(irq_n),
		.O_IRQ_OE_N(irq_oe_n), .I_CHAIN_ENABLE_IN(chain_enable_in),
		.O_CHAIN_ENABLE_OUT(chain_enable_out), .I_EV_TX_EMPTY(ev[2]),
		.I_EV_RX_AVAIL(ev[1]), .I_EV_ERROR(ev[0]), .I_EV_STAT_CHG(ev[3]),
		.I_RX_DATA(rx_data), .O_RX_READ(rx_read), .O_TX_DATA(tx_data),
		.O_TX_LOAD(tx_load), .O_CHIP_RESET(chip_reset));

	task print_verdict();
		if (failures == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task pulse(input logic [3:0] m);
		@(negedge clk);
		ev = m;
		@(negedge clk);
		ev = 4'h0;
		repeat (5) @(negedge clk);
	endtask : pulse

	// The whole run needs about 530 cycles; the ceiling leaves wide margin.
	// Pulses are counted on the falling edge, where the outputs have settled.
	always @(negedge clk)
	begin
		cycles++;
		if (tx_load === 1'b1)
			tx_loads++;
		if (rx_read === 1'b1)
			rx_reads++;
		if (chip_reset === 1'b1)
			resets++;
		if (cycles == 20000)
		begin
			failures++;
			print_verdict();
		end
	end

	initial
	begin
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		chk({5'h00, dev_oe_n, irq_oe_n, chain_enable_out}, 8'h07);
		sbic_host_model_inst.access(1'b0, REG_VECTOR, 8'hA4, d);
		for (int i = 0; i < 4; i++)
		begin
			pulse(rows[i].ev);
			chk({7'h00, irq_wire}, 8'h00);
			sbic_host_model_inst.access(1'b1, REG_CTRL, 8'h00, d);
			chk(d, {4'h0, rows[i].ev});
			sbic_host_model_inst.ack(d);
			chk(d, rows[i].vec);
			sbic_host_model_inst.access(1'b1, REG_CTRL, 8'h00, d);
			chk(d, {rows[i].ev, rows[i].ev});
			chk({6'h00, irq_wire, chain_enable_out}, 8'h02);
			sbic_host_model_inst.access(rows[i].rd, rows[i].sel, rows[i].wd, d);
			if (rows[i].rd)
				chk(d, rx_data);
			sbic_host_model_inst.access(1'b1, REG_CTRL, 8'h00, d);
			chk(d, {rows[i].ev, 4'h0});
			sbic_host_model_inst.access(1'b0, REG_CTRL, CMD_RST_IN_SERVICE, d);
			sbic_host_model_inst.access(1'b1, REG_CTRL, 8'h00, d);
			chk(d, 8'h00);
			chk({6'h00, irq_wire, chain_enable_out}, 8'h03);
		end
		chk(tx_data, 8'h5A);
		chk(8'(tx_loads * 16 + rx_reads), 8'h11);
		// Acknowledge held open: a new event must not raise a request.
		sbic_host_model_inst.set_ack(1'b0);
		pulse(4'h1);
		chk({6'h00, irq_wire, chain_enable_out}, 8'h02);
		sbic_host_model_inst.set_ack(1'b1);
		repeat (6) @(negedge clk);
		chk({6'h00, irq_wire, chain_enable_out}, 8'h01);
		chain_enable_in = 1'b0;
		repeat (6) @(negedge clk);
		chk({6'h00, irq_wire, chain_enable_out}, 8'h02);
		sbic_host_model_inst.ack(d);
		sbic_host_model_inst.access(1'b1, REG_CTRL, 8'h00, d);
		chk(d, 8'h01);
		chain_enable_in = 1'b1;
		sbic_host_model_inst.access(1'b0, REG_CTRL, CMD_LOWER_CHAIN_DISABLE, d);
		chk({7'h00, chain_enable_out}, 8'h00);
		sbic_host_model_inst.access(1'b0, REG_CTRL, CMD_LOWER_CHAIN_ENABLE, d);
		chk({7'h00, chain_enable_out}, 8'h01);
		sbic_host_model_inst.strobe_reset();
		chk(8'(resets > 0), 8'h01);
		sbic_host_model_inst.access(1'b1, REG_CTRL, 8'h00, d);
		chk(d, 8'h00);
		chk({7'h00, dev_oe_n}, 8'h01);
		print_verdict();
	end
endmodule : test_sbic_host_port
